// ===== design/dtc_pkg.sv
// Purpose: shared constants and types of the dual timebase capture timer
// Assumes: 8-bit register port, clk_i is the oscillator clock
// Notes: offsets are byte addresses on the register port

package dtc_pkg;

  // -------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------
  localparam logic [7:0] TICK2_CTRL_OFS = 8'h08;
  localparam logic [7:0] TICK2_RELOAD_OFS = 8'h09;
  localparam logic [7:0] TICK2_COUNT_OFS = 8'h0A;
  localparam logic [7:0] TICK1_CAP_CTRL_OFS = 8'h0B;
  localparam logic [7:0] CAPTURE_VALUE_OFS = 8'h0C;

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int TICK2_FLAG_BIT = 0;
  localparam int TICK2_IE_BIT = 1;
  localparam int TICK1_FLAG_BIT = 3;
  localparam int TICK1_IE_BIT = 4;
  localparam int TICK1_SEL_BIT = 5;
  localparam int CAP_FLAG_BIT = 6;
  localparam int CAP_IE_BIT = 7;

  // -------------------------------------------------------------
  // reset values and counter limits
  // -------------------------------------------------------------
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] CAPTURE_RESET = 8'h00;
  localparam logic [7:0] TICK1_WRAP = 8'hF9;
  localparam logic [7:0] TICK2_TOP = 8'hFF;
  localparam int PRESCALE_DIV = 32;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtc_req_s;

  // interrupt request lines
  typedef struct packed {
    logic tick1;
    logic tick2;
    logic capture;
  } dtc_irq_s;

endpackage

// ===== design/dtc_prescaler.sv
// Purpose: oscillator divider giving a one-cycle count enable
// Assumes: halt_i freezes the divider
// Notes: en_o is registered

`timescale 1ns/1ns
`default_nettype none

module dtc_prescaler #(
  parameter int DIV = dtc_pkg::PRESCALE_DIV
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic halt_i,
  output logic en_o
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [$clog2(DIV)-1:0] cnt;
    logic en;
  } dtc_div_s;

  dtc_div_s state_q;
  dtc_div_s state_d;

  // divider step, stands still while halted
  always_comb
  begin
    state_d = state_q;
    // while halted a pending pulse waits, so no tick is lost
    if (!halt_i)
    begin
      state_d.en = 1'b0;
      state_d.cnt = state_q.cnt + ($clog2(DIV))'(1);
      if (state_q.cnt == ($clog2(DIV))'(DIV - 1))
      begin
        state_d.cnt = '0;
        state_d.en = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign en_o = state_q.en;

endmodule

`default_nettype wire

// ===== design/dtc_top.sv
// Purpose: two 8-bit timebase counters and an 8-bit input capture
// Assumes: clk_i is the oscillator, inputs synchronous to it
// Notes: flags clear on register reads, a set in the same cycle wins
//
// What this block does
// RULE_01: counter1 starts at zero, hidden, osc/32
// RULE_02: counter1 wraps F9h to 00h, overflow
// RULE_03: period 8000 cycles, or 16000 when selected
// RULE_04: overflow sets tick1 flag, enabled irq
// RULE_05: reading tick1 control clears tick1 flag
// RULE_06: pin edge latches counter1, sets capture flag
// RULE_07: no capture while capture flag set
// RULE_08: reading capture value clears capture flag
// RULE_09: enabled capture event requests interrupt
// RULE_10: software reads capture value after reset
// RULE_11: counter2 starts at reload, readable, osc/32
// RULE_12: counter2 past FFh loads reload, overflow
// RULE_13: reload writes reach counter2 at overflow
// RULE_14: counter2 overflow sets tick2 flag, irq
// RULE_15: reading tick2 control clears tick2 flag
// RULE_16: halt stops counters, other modes run
// RULE_17: three separate interrupt request lines
// RULE_18: interrupts only while global mask clear
// RULE_19: software writes zero to tick2 bits 7:2
// RULE_20: tick1 wakes wait and active-halt, others wait
//
// Implementation choices: the register offsets and the address-and-strobe port.

`timescale 1ns/1ns
`default_nettype none

module dtc_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic capture_input_pin_i,
  input wire logic halt_i,
  input wire logic global_mask_i,
  output logic irq_tick1_o,
  output logic irq_tick2_o,
  output logic irq_capture_o,
  output logic wake_wait_o,
  output logic wake_active_halt_o
);

  // -------------------------------------------------------------
  // state of the block
  // -------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cnt1;           // hidden timebase counter
    logic half;                 // second wrap marker for long period
    logic [7:0] cnt2;           // autoreload counter
    logic [7:0] reload;         // reload value
    logic [7:0] capture;        // captured counter1 value
    logic pin_prev;             // last capture pin sample
    logic tick1_flag;
    logic tick1_irq_enable;
    logic tick1_period_select;
    logic tick2_flag;
    logic tick2_irq_enable;
    logic capture_flag;
    logic capture_irq_enable;
    logic [7:0] rdata;
    dtc_pkg::dtc_irq_s irq;     // registered request lines
    logic wake_wait;
    logic wake_ahalt;
  } dtc_state_s;

  dtc_state_s s_q;
  dtc_state_s s_d;
  dtc_pkg::dtc_req_s req;
  logic div_en;
  logic tick;                   // counters advance this cycle
  logic wrap1;
  logic ovf1;
  logic ovf2;
  logic edge_seen;
  logic rd_t1;
  logic rd_t2;
  logic rd_cap;
  dtc_pkg::dtc_irq_s irq_d;

  // -------------------------------------------------------------
  // oscillator divider
  // -------------------------------------------------------------
  dtc_prescaler #(
    .DIV(dtc_pkg::PRESCALE_DIV)
  ) u_prescaler (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .halt_i(halt_i),
    .en_o(div_en)
  );

  // request bundle
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // -------------------------------------------------------------
  // event decode
  // -------------------------------------------------------------
  // RULE_16 halt gates the count enable
  assign tick = div_en & ~halt_i;
  assign wrap1 = tick & (s_q.cnt1 == dtc_pkg::TICK1_WRAP);
  // RULE_03 long period counts every second wrap
  assign ovf1 = wrap1 & (~s_q.tick1_period_select | s_q.half);
  assign ovf2 = tick & (s_q.cnt2 == dtc_pkg::TICK2_TOP);
  assign edge_seen = capture_input_pin_i ^ s_q.pin_prev;
  // read strobes per register
  assign rd_t1 = req.rd & (req.addr == dtc_pkg::TICK1_CAP_CTRL_OFS);
  assign rd_t2 = req.rd & (req.addr == dtc_pkg::TICK2_CTRL_OFS);
  assign rd_cap = req.rd & (req.addr == dtc_pkg::CAPTURE_VALUE_OFS);

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.pin_prev = capture_input_pin_i;

    // RULE_01 counter1 advances on the divided tick
    if (tick)
    begin
      s_d.cnt1 = s_q.cnt1 + 8'h01;
    end
    // RULE_02 wrap after F9h
    if (wrap1)
    begin
      s_d.cnt1 = 8'h00;
      s_d.half = ~s_q.half;
    end
    // short period keeps the marker cleared
    if (!s_q.tick1_period_select)
    begin
      s_d.half = 1'b0;
    end

    // RULE_11 counter2 advances on the divided tick
    if (tick)
    begin
      s_d.cnt2 = s_q.cnt2 + 8'h01;
    end
    // RULE_12 RULE_13 reload only at overflow
    if (ovf2)
    begin
      s_d.cnt2 = s_q.reload;
    end

    // register writes, flags are not writable
    if (req.wr)
    begin
      case (req.addr)
        dtc_pkg::TICK2_CTRL_OFS:
        begin
          s_d.tick2_irq_enable = req.wdata[dtc_pkg::TICK2_IE_BIT];
        end
        dtc_pkg::TICK2_RELOAD_OFS:
        begin
          s_d.reload = req.wdata;
        end
        dtc_pkg::TICK1_CAP_CTRL_OFS:
        begin
          s_d.capture_irq_enable = req.wdata[dtc_pkg::CAP_IE_BIT];
          s_d.tick1_period_select = req.wdata[dtc_pkg::TICK1_SEL_BIT];
          s_d.tick1_irq_enable = req.wdata[dtc_pkg::TICK1_IE_BIT];
        end
        default:
        begin
          s_d.reload = s_q.reload;
        end
      endcase
    end

    // RULE_05 read clears, set below wins
    if (rd_t1)
    begin
      s_d.tick1_flag = 1'b0;
    end
    // RULE_04 overflow sets tick1 flag
    if (ovf1)
    begin
      s_d.tick1_flag = 1'b1;
    end

    // RULE_15 read clears tick2 flag
    if (rd_t2)
    begin
      s_d.tick2_flag = 1'b0;
    end
    // RULE_14 overflow sets tick2 flag
    if (ovf2)
    begin
      s_d.tick2_flag = 1'b1;
    end

    // RULE_08 reading the capture value clears the flag
    if (rd_cap)
    begin
      s_d.capture_flag = 1'b0;
    end
    // RULE_06 RULE_07 capture only while flag clear
    if (edge_seen && !s_q.capture_flag)
    begin
      s_d.capture = s_q.cnt1;
      s_d.capture_flag = 1'b1;
    end

    // read data, valid the cycle after the strobe
    s_d.rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        dtc_pkg::TICK2_CTRL_OFS:
        begin
          s_d.rdata[dtc_pkg::TICK2_IE_BIT] = s_q.tick2_irq_enable;
          s_d.rdata[dtc_pkg::TICK2_FLAG_BIT] = s_q.tick2_flag;
        end
        dtc_pkg::TICK2_RELOAD_OFS:
        begin
          s_d.rdata = s_q.reload;
        end
        dtc_pkg::TICK2_COUNT_OFS:
        begin
          s_d.rdata = s_q.cnt2;
        end
        dtc_pkg::TICK1_CAP_CTRL_OFS:
        begin
          s_d.rdata[dtc_pkg::CAP_IE_BIT] = s_q.capture_irq_enable;
          s_d.rdata[dtc_pkg::CAP_FLAG_BIT] = s_q.capture_flag;
          s_d.rdata[dtc_pkg::TICK1_SEL_BIT] = s_q.tick1_period_select;
          s_d.rdata[dtc_pkg::TICK1_IE_BIT] = s_q.tick1_irq_enable;
          s_d.rdata[dtc_pkg::TICK1_FLAG_BIT] = s_q.tick1_flag;
        end
        dtc_pkg::CAPTURE_VALUE_OFS:
        begin
          s_d.rdata = s_q.capture;
        end
        default:
        begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // RULE_17 RULE_18 separate lines gated by global mask
    irq_d.tick1 = s_q.tick1_flag & s_q.tick1_irq_enable & ~global_mask_i;
    irq_d.tick2 = s_q.tick2_flag & s_q.tick2_irq_enable & ~global_mask_i;
    // RULE_09 enabled capture requests interrupt
    irq_d.capture = s_q.capture_flag & s_q.capture_irq_enable & ~global_mask_i;
    s_d.irq = irq_d;
    // RULE_20 wake sources per low power mode
    s_d.wake_wait = irq_d.tick1 | irq_d.tick2 | irq_d.capture;
    s_d.wake_ahalt = irq_d.tick1;
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_q <= '0;
      s_q.reload <= dtc_pkg::RELOAD_RESET;
      s_q.cnt2 <= dtc_pkg::RELOAD_RESET;
      s_q.capture <= dtc_pkg::CAPTURE_RESET;
      // track the pin in reset, so no false edge at release
      s_q.pin_prev <= capture_input_pin_i;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rdata_o = s_q.rdata;
  assign irq_tick1_o = s_q.irq.tick1;
  assign irq_tick2_o = s_q.irq.tick2;
  assign irq_capture_o = s_q.irq.capture;
  assign wake_wait_o = s_q.wake_wait;
  assign wake_active_halt_o = s_q.wake_ahalt;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_wrap1;
    tick && s_q.cnt1 == dtc_pkg::TICK1_WRAP;
  endsequence

  sequence s_top2;
    tick && s_q.cnt2 == dtc_pkg::TICK2_TOP;
  endsequence

  // RULE_02 wrap to zero
  cnt1_wrap_a: assert property (s_wrap1 |=> s_q.cnt1 == 8'h00) // RULE_02
    else $error("counter1 did not wrap to zero");
  // RULE_01 counter1 holds between ticks
  cnt1_hold_a: assert property (!tick |=> $stable(s_q.cnt1)) // RULE_01
    else $error("counter1 moved without a tick");
  // RULE_03 short period sets flag at wrap
  tick1_period_a: assert property (s_wrap1 ##0 !s_q.tick1_period_select
      |=> s_q.tick1_flag) // RULE_03
    else $error("short period overflow missed");
  // RULE_05 read clears when no overflow
  tick1_clear_a: assert property (rd_t1 && !ovf1 |=> !s_q.tick1_flag) // RULE_05
    else $error("tick1 flag not cleared by read");
  // RULE_06 capture takes counter1
  cap_latch_a: assert property (edge_seen && !s_q.capture_flag
      |=> s_q.capture_flag && s_q.capture == $past(s_q.cnt1)) // RULE_06
    else $error("capture value wrong");
  // RULE_07 value held while flag set
  cap_hold_a: assert property (s_q.capture_flag |=> $stable(s_q.capture)) // RULE_07
    else $error("capture overwritten while flag set");
  // RULE_08 capture read clears flag
  cap_clear_a: assert property (rd_cap |=> !s_q.capture_flag
      || $past(edge_seen)) // RULE_08
    else $error("capture flag not cleared by read");
  // RULE_12 counter2 reloads
  cnt2_reload_a: assert property (s_top2 |=> s_q.cnt2 == $past(s_q.reload)
      && s_q.tick2_flag) // RULE_12
    else $error("counter2 reload or flag wrong");
  // RULE_16 halt freezes both counters
  halt_freeze_a: assert property (halt_i |=> $stable(s_q.cnt1)
      && $stable(s_q.cnt2)) // RULE_16
    else $error("counter moved in halt");
  // RULE_18 masked interrupts stay low
  irq_mask_a: assert property (global_mask_i |=> !irq_tick1_o
      && !irq_tick2_o && !irq_capture_o) // RULE_18
    else $error("interrupt while globally masked");

endmodule

`default_nettype wire

// ===== tb/test_dtc_top.sv
// Purpose: self-checking bench for the dual timebase capture timer
// Assumes: register read data stand in the cycle after the read strobe
// Notes: outputs are sampled on the falling edge so no race with the design

`timescale 1ns/1ns
`default_nettype none

module test_dtc_top;
  // ---------------------------------------------
  // design signals and bench state
  // ---------------------------------------------
  logic clk_i;
  logic reset_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic cap_pin;
  logic halt_i;
  logic mask_i;
  wire [2:0] irqs; // tick1, tick2, capture
  logic wake_w;
  logic wake_ah;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0; // free running cycle count
  int t0;
  int t1;
  logic [1:0] w;
  logic [7:0] a;
  logic [7:0] b;

  dtc_top dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .capture_input_pin_i(cap_pin),
    .halt_i(halt_i),
    .global_mask_i(mask_i),
    .irq_tick1_o(irqs[2]),
    .irq_tick2_o(irqs[1]),
    .irq_capture_o(irqs[0]),
    .wake_wait_o(wake_w),
    .wake_active_halt_o(wake_ah)
  );

  // 125 MHz clock and cycle counter
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) cyc <= cyc + 1;

  // ---------------------------------------------
  // bus tasks and compares
  // ---------------------------------------------
  // one write, strobe high for one cycle
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // one read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
    @(posedge clk_i);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // cycle spans between events
  task automatic chk_t(input int got, input int exp);
    checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    rd(ad, d);
    chk(d, exp);
  endtask

  // wait for an irq line, note its cycle and the wake outputs one cycle on
  task automatic wait_irq(input int k, output int t, output logic [1:0] wk);
    int i;
    for (i = 0; i < 20000; i++)
    begin
      @(negedge clk_i);
      if (irqs[k] === 1'b1)
        break;
    end
    if (i == 20000)
      n_mismatch++;
    t = cyc;
    @(negedge clk_i);
    wk = {wake_w, wake_ah};
    @(posedge clk_i);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end

  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial
  begin
    reset_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    cap_pin = 1'b0;
    halt_i = 1'b0;
    mask_i = 1'b0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    // reset values, unmapped place, reload access
    rdchk(dtc_pkg::TICK2_COUNT_OFS, 8'h00);
    rdchk(dtc_pkg::TICK2_CTRL_OFS, 8'h00);
    rdchk(dtc_pkg::TICK2_RELOAD_OFS, 8'h00);
    rdchk(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h00);
    rdchk(dtc_pkg::CAPTURE_VALUE_OFS, 8'h00);
    rdchk(8'h0D, 8'h00);
    wr(dtc_pkg::TICK2_RELOAD_OFS, 8'hF0);
    rdchk(dtc_pkg::TICK2_RELOAD_OFS, 8'hF0);
    rd(dtc_pkg::TICK2_COUNT_OFS, a);
    repeat (30) @(posedge clk_i);
    rd(dtc_pkg::TICK2_COUNT_OFS, b);
    chk(b, a + 8'h01);
    chk(8'(a < 8'hF0), 8'h01);
    $display("test registers done");
    // capture, inhibited capture, flag clear by read
    wr(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h80);
    cap_pin <= ~cap_pin;
    repeat (64) @(posedge clk_i);
    cap_pin <= ~cap_pin;
    repeat (6) @(negedge clk_i);
    chk(8'(irqs), 8'h01);
    @(posedge clk_i);
    rd(dtc_pkg::CAPTURE_VALUE_OFS, a);
    repeat (248) @(posedge clk_i);
    cap_pin <= ~cap_pin;
    repeat (6) @(negedge clk_i);
    @(posedge clk_i);
    rdchk(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'hC0);
    rdchk(dtc_pkg::CAPTURE_VALUE_OFS, 8'((a + 10) % 250));
    rdchk(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h80);
    wr(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h48);
    rdchk(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h00);
    wr(dtc_pkg::TICK2_CTRL_OFS, 8'h01);
    rdchk(dtc_pkg::TICK2_CTRL_OFS, 8'h00);
    $display("test capture done");
    // second counter reload and periods
    wr(dtc_pkg::TICK2_CTRL_OFS, 8'h02);
    wait_irq(1, t0, w);
    rdchk(dtc_pkg::TICK2_COUNT_OFS, 8'hF0);
    rdchk(dtc_pkg::TICK2_CTRL_OFS, 8'h03);
    wr(dtc_pkg::TICK2_RELOAD_OFS, 8'hF8);
    wait_irq(1, t1, w);
    chk_t(t1 - t0, 512);
    chk(8'(w), 8'h02);
    rdchk(dtc_pkg::TICK2_CTRL_OFS, 8'h03);
    wait_irq(1, t0, w);
    chk_t(t0 - t1, 256);
    $display("test tick2 done");
    // halt freezes, global mask blocks the line
    halt_i <= 1'b1;
    rd(dtc_pkg::TICK2_COUNT_OFS, a);
    repeat (100) @(posedge clk_i);
    rd(dtc_pkg::TICK2_COUNT_OFS, b);
    chk(b, a);
    halt_i <= 1'b0;
    mask_i <= 1'b1;
    rd(dtc_pkg::TICK2_CTRL_OFS, a);
    t0 = 0;
    repeat (300)
    begin
      @(negedge clk_i);
      if (irqs[1] !== 1'b0)
        t0++;
    end
    chk_t(t0, 0);
    @(posedge clk_i);
    mask_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(8'(irqs[1]), 8'h01);
    @(posedge clk_i);
    rdchk(dtc_pkg::TICK2_CTRL_OFS, 8'h03);
    $display("test halt and mask done");
    // first counter periods, short then long
    wr(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h10);
    rd(dtc_pkg::TICK1_CAP_CTRL_OFS, a);
    wait_irq(2, t0, w);
    chk(8'(w), 8'h03);
    rdchk(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h18);
    wait_irq(2, t1, w);
    chk_t(t1 - t0, 8000);
    rdchk(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h18);
    wr(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h30);
    wait_irq(2, t0, w);
    rdchk(dtc_pkg::TICK1_CAP_CTRL_OFS, 8'h38);
    wait_irq(2, t1, w);
    chk_t(t1 - t0, 16000);
    $display("test tick1 done");
    summarize();
  end
endmodule

`default_nettype wire
